// ### verilog/ebc_top.sv
/*
 * External bus controller with port six and port two pin logic.
 * Assumes a core that issues one request at a time and routes answers
 * flagged internal to its own RAM and register areas.
 */
`timescale 1ns/10ps

// Functional notes
// - Every port pin has a direction bit; input pins float unless a port six alternate function drives them.
// - Port six and two outputs choose push-pull or open-drain.
// - Port six: chip selects on 0-4, hold in, grant 6, bus want 7.
// - Port two bits 8-15 feed fast interrupt inputs 0-7.
// - One 16 MByte space, byte or word access everywhere.
// - 2 KByte internal RAM window is served internally.
// - Two 512-byte register areas are served internally.
// - No ROM; all other code is fetched externally.
// - Single chip mode or four external data/multiplex modes.
// - Demux: address on port one, data on port zero; mux shares zero.
// - Wait states, tri-state, ALE length, strobe delay programmable.
// - Each address range uses its own timing set.
// - Up to five active-low chip selects, one per range.
// - Ready handshake stretches slow accesses.
// - Hold request answered with grant after bus release.
// - Space limit sets port four to 0, 2, 4 or 8 lines.
// - Ready high during access inserts waits until low.
// - Low-byte write mode gates the write strobe.
// - Read strobe for every external fetch or read, except with strobe delay and zero wait states.
// - Demux 16-bit uses all port zero; 8-bit leaves high byte.
module ebc_top
    import ebc_pkg::*;
#(
    parameter int NUM_CS = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic cfg_load,
    input wire logic [2:0] cfg_mode,
    input wire logic [1:0] cfg_space,
    input wire logic cfg_ready_en,
    input wire logic write_strobe_cfg,
    input wire logic cfg_cs_en,
    input wire logic cfg_hold_en,
    input wire logic [NUM_CS*RNG_W-1:0] rng_base,
    input wire logic [NUM_CS*RNG_W-1:0] rng_mask,
    input wire logic [NUM_CS*TIM_W-1:0] rng_timing,
    // Core request and answer
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [23:0] req_addr,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_internal,
    output logic rsp_error,
    output logic [15:0] rsp_rdata,
    // External bus pins
    input wire logic [15:0] addr_data_port_in,
    output logic [15:0] addr_data_port_out,
    output logic [15:0] addr_data_port_oe,
    output logic [15:0] addr_only_port_out,
    output logic [15:0] addr_only_port_oe,
    output logic [7:0] addr_high_out,
    output logic [7:0] addr_high_oe,
    output logic ale,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic strobe_oe,
    input wire logic mem_wait_in,
    // Port six and port two pins
    input wire logic [7:0] p6_pin_in,
    output logic [7:0] p6_pin_out,
    output logic [7:0] p6_pin_oe,
    input wire logic [7:0] p6_dir,
    input wire logic [7:0] p6_od,
    input wire logic [7:0] p6_gpio_out,
    input wire logic [7:0] p2_pin_in,
    output logic [7:0] p2_pin_out,
    output logic [7:0] p2_pin_oe,
    input wire logic [7:0] p2_dir,
    input wire logic [7:0] p2_od,
    input wire logic [7:0] p2_gpio_out,
    output logic [7:0] fast_irq_in
);

    initial begin
        if (NUM_CS < 1 || NUM_CS > 5) begin
            $error("NUM_CS must lie between 1 and 5");
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [2:0] mode_q;
    logic [1:0] space_q;
    logic ready_en_q;
    logic wcfg_q;

    // Reset lands in 16-bit demultiplexed mode so the first fetch works.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
            space_q <= SP_RESET;
            ready_en_q <= 1'b0;
            wcfg_q <= 1'b0;
        end else if (cfg_load) begin
            mode_q <= cfg_mode;
            space_q <= cfg_space;
            ready_en_q <= cfg_ready_en;
            wcfg_q <= write_strobe_cfg;
        end
    end

    // ************************************************************
    // Decode of the request
    // ************************************************************
    ebc_state_t state_q;
    logic [23:0] addr_q;
    logic [15:0] wdata_q;
    logic wr_q;
    logic byte_q;
    logic half_q;
    logic first_q;
    logic [3:0] cnt_q;
    logic [2:0] sel_q;
    logic [2:0] sel_d;
    logic [TIM_W-1:0] tim;
    logic internal_hit;
    logic mux;
    logic bus8;
    logic bus_own;
    logic hold_take;
    logic active;
    logic strobe_on;

    assign mux = (mode_q == MODE_MUX16) || (mode_q == MODE_MUX8);
    assign bus8 = (mode_q == MODE_MUX8) || (mode_q == MODE_DMX8);
    assign hold_take = cfg_hold_en && !p6_pin_in[HOLD_PIN];
    // Internal RAM and both register areas run no bus cycle; in demultiplexed modes their address still shows on port one.
    assign internal_hit = (req_addr >= RAM_LO && req_addr <= RAM_HI)
        || (req_addr >= SREG_LO && req_addr <= SREG_HI)
        || (req_addr >= XREG_LO && req_addr <= XREG_HI);

    // Lowest numbered matching range wins; no match uses set zero.
    always_comb begin
        sel_d = 3'h0;
        for (int i = NUM_CS - 1; i >= 1; i--) begin
            if ((req_addr[23:12] & rng_mask[i*RNG_W +: RNG_W])
                == rng_base[i*RNG_W +: RNG_W]) begin
                sel_d = 3'(i);
            end
        end
    end

    assign tim = rng_timing[sel_q*TIM_W +: TIM_W];
    // Requests stall while hold is pending or granted.
    assign req_ready = (state_q == ST_IDLE) && !hold_take;

    // ************************************************************
    // Access sequencer
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    half_q <= 1'b0;
                    if (hold_take) begin
                        state_q <= ST_HOLD;
                    end else if (req_valid && !internal_hit && mode_q != MODE_SINGLE) begin
                        state_q <= ST_ALE;
                        cnt_q <= {3'h0, rng_timing[sel_d*TIM_W + TIM_ALE_BIT]};
                    end
                end
                ST_ALE: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_CMD;
                        cnt_q <= tim[TIM_WAIT_LSB +: 4];
                        first_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_CMD: begin
                    first_q <= 1'b0;
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (ready_en_q && mem_wait_in) begin
                        state_q <= ST_CMD;
                    end else if (bus8 && !byte_q && !half_q) begin
                        half_q <= 1'b1;
                        state_q <= ST_ALE;
                        cnt_q <= {3'h0, tim[TIM_ALE_BIT]};
                    end else begin
                        state_q <= tim[TIM_TRI_BIT] ? ST_TRI : ST_IDLE;
                    end
                end
                ST_TRI: state_q <= ST_IDLE;
                ST_HOLD: begin
                    if (!hold_take) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Request latches; the address steps to the odd byte on an 8-bit bus.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_q <= 24'h000000;
            wdata_q <= 16'h0000;
            wr_q <= 1'b0;
            byte_q <= 1'b0;
            sel_q <= 3'h0;
        end else if (req_valid && req_ready) begin
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            wr_q <= req_write;
            byte_q <= req_byte;
            sel_q <= sel_d;
        end else if (state_q == ST_CMD && cnt_q == 4'h0 && bus8 && !byte_q
            && !half_q && !(ready_en_q && mem_wait_in)) begin
            addr_q <= addr_q + 24'h000001;
        end
    end

    // ************************************************************
    // Answers to the core
    // ************************************************************
    logic done;

    assign done = state_q == ST_CMD && cnt_q == 4'h0 && !(ready_en_q && mem_wait_in);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_internal <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= (req_valid && req_ready && (internal_hit || mode_q == MODE_SINGLE))
                || (done && !(bus8 && !byte_q && !half_q));
            rsp_internal <= req_valid && req_ready && internal_hit;
            rsp_error <= req_valid && req_ready && !internal_hit && mode_q == MODE_SINGLE;
            if (done && !wr_q) begin
                if (!bus8) begin
                    rsp_rdata <= addr_data_port_in;
                end else if (addr_q[0]) begin
                    rsp_rdata[15:8] <= addr_data_port_in[7:0];
                end else begin
                    rsp_rdata[7:0] <= addr_data_port_in[7:0];
                end
            end
        end
    end

    // ************************************************************
    // Bus pins
    // ************************************************************
    logic [7:0] lo_byte;
    logic wr_sel;

    assign active = state_q == ST_ALE || state_q == ST_CMD;
    assign bus_own = mode_q != MODE_SINGLE && state_q != ST_HOLD;
    assign strobe_on = state_q == ST_CMD && !(tim[TIM_RWD_BIT] && first_q);
    assign lo_byte = (bus8 && addr_q[0]) ? wdata_q[15:8] : wdata_q[7:0];
    // Low-byte mode still strobes odd bytes on an 8-bit bus.
    assign wr_sel = !wcfg_q || bus8 || !byte_q || !addr_q[0];

    assign ale = state_q == ST_ALE;
    assign read_strobe_n = !(strobe_on && !wr_q);
    assign write_strobe_n = !(strobe_on && wr_q && wr_sel);
    assign strobe_oe = bus_own;
    assign addr_data_port_out = (state_q == ST_ALE) ? addr_q[15:0]
        : {bus8 ? addr_q[15:8] : wdata_q[15:8], lo_byte};
    // The 8-bit demultiplexed high byte stays general I/O.
    assign addr_data_port_oe = {
        {8{(ale && mux) || (state_q == ST_CMD && wr_q && !bus8)
            || (mode_q == MODE_MUX8 && active)}},
        {8{(ale && mux) || (state_q == ST_CMD && wr_q)}}};
    assign addr_only_port_out = addr_q[15:0];
    assign addr_only_port_oe = {16{bus_own && !mux}};
    assign addr_high_out = addr_q[23:16];

    // Upper lines follow the configured space size.
    always_comb begin
        case (space_q)
            SP_64K: addr_high_oe = 8'h00;
            SP_256K: addr_high_oe = 8'h03;
            SP_1M: addr_high_oe = 8'h0F;
            default: addr_high_oe = 8'hFF;
        endcase
        if (!bus_own) begin
            addr_high_oe = 8'h00;
        end
    end

    // ************************************************************
    // Port six and port two pin drivers
    // ************************************************************
    logic [7:0] alt6_val;
    logic [7:0] alt6_on;
    logic [4:0] cs_n;
    logic bus_release_grant_n;
    logic bus_want_back_n;

    always_comb begin
        cs_n = 5'h1F;
        if (active && sel_q < 3'(NUM_CS)) begin
            cs_n[sel_q] = 1'b0;
        end
    end

    assign bus_release_grant_n = state_q != ST_HOLD;
    assign bus_want_back_n = !(state_q == ST_HOLD && req_valid);
    assign alt6_val = {bus_want_back_n, bus_release_grant_n, 1'b1, cs_n};
    // Chip selects hand their pins back to port six general I/O under hold; the rest of the bus floats.
    assign alt6_on = {{2{cfg_hold_en}}, 1'b0,
        {5{cfg_cs_en && bus_own}} & ((5'h1 << NUM_CS) - 5'h1)};
    assign fast_irq_in = p2_pin_in;

    // Open-drain pins only ever drive low; input pins float except port six pins with an active alternate function.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p6_pin_out[i] = alt6_on[i] ? alt6_val[i] : p6_gpio_out[i];
            p6_pin_oe[i] = (p6_dir[i] || alt6_on[i]) && !(p6_od[i] && p6_pin_out[i]);
            p2_pin_out[i] = p2_gpio_out[i];
            p2_pin_oe[i] = p2_dir[i] && !(p2_od[i] && p2_gpio_out[i]);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence wait_seen_s;
        state_q == ST_CMD && cnt_q == 4'h0 && ready_en_q && mem_wait_in;
    endsequence

    hold_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_HOLD |-> addr_data_port_oe == 16'h0000 && !strobe_oe
            && addr_high_oe == 8'h00 && !req_ready)
        else $error("bus driven during hold");
    grant_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(bus_release_grant_n) |-> $past(state_q == ST_IDLE) && !active)
        else $error("grant without bus release");
    ready_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wait_seen_s |=> state_q == ST_CMD && !rsp_valid)
        else $error("ready wait ignored");
    read_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_CMD && !wr_q && !first_q |-> !read_strobe_n)
        else $error("read strobe missing");
    low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !write_strobe_n && wcfg_q && !bus8 |-> !(byte_q && addr_q[0]))
        else $error("high byte write strobed");
    one_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $onehot0(~cs_n) && (active == (cs_n != 5'h1F || sel_q >= 3'(NUM_CS))))
        else $error("chip select fault");
    space_lines_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_own && space_q == SP_256K |-> addr_high_oe == 8'h03)
        else $error("upper address lines wrong");
    reset_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(!rst_n) |-> mode_q == MODE_DMX16 && state_q == ST_IDLE)
        else $error("reset mode wrong");
    open_drain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        p6_od[0] && p6_pin_out[0] |-> !p6_pin_oe[0])
        else $error("open drain drives high");
    single_chip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_q == MODE_SINGLE && $stable(mode_q) |-> !ale && read_strobe_n)
        else $error("bus cycle in single chip mode");

endmodule // ebc_top

// ### verilog/ebc_pkg.sv
/*
 * Constants shared by the external bus controller: bus modes, address
 * space codes, internal address windows, timing fields and states.
 * Assumes nothing of its surroundings.
 */
package ebc_pkg;

    // ************************************************************
    // Bus modes and address space sizes
    // ************************************************************
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_DMX16 = 3'h1;
    localparam logic [2:0] MODE_MUX16 = 3'h2;
    localparam logic [2:0] MODE_MUX8 = 3'h3;
    localparam logic [2:0] MODE_DMX8 = 3'h4;
    localparam logic [2:0] MODE_RESET = MODE_DMX16;
    localparam logic [1:0] SP_64K = 2'h0;
    localparam logic [1:0] SP_256K = 2'h1;
    localparam logic [1:0] SP_1M = 2'h2;
    localparam logic [1:0] SP_16M = 2'h3;
    localparam logic [1:0] SP_RESET = SP_16M;

    // ************************************************************
    // Internal windows: RAM (2 KByte) and two 512-byte register areas
    // ************************************************************
    localparam logic [23:0] RAM_LO = 24'h00F600;
    localparam logic [23:0] RAM_HI = 24'h00FDFF;
    localparam logic [23:0] SREG_LO = 24'h00FE00;
    localparam logic [23:0] SREG_HI = 24'h00FFFF;
    localparam logic [23:0] XREG_LO = 24'h00F000;
    localparam logic [23:0] XREG_HI = 24'h00F1FF;

    // ************************************************************
    // Timing set fields: waits, long ALE, read/write delay, tri-state
    // ************************************************************
    localparam int TIM_W = 7;
    localparam int TIM_WAIT_LSB = 0;
    localparam int TIM_ALE_BIT = 4;
    localparam int TIM_RWD_BIT = 5;
    localparam int TIM_TRI_BIT = 6;
    localparam int RNG_W = 12;
    localparam int HOLD_PIN = 5;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ALE = 5'h02,
        ST_CMD = 5'h04,
        ST_TRI = 5'h08,
        ST_HOLD = 5'h10
    } ebc_state_t;

endpackage

// ### verif/ebc_mem_model.sv
/*
 * Behavioural external memory for the bus controller bench.
 * Assumes a demultiplexed bus: address on the address-only port, data on port zero.
 */
`timescale 1ns/10ps

module ebc_mem_model (
    // Clock
    input wire logic core_clk,
    // Bus pins seen by the memory
    input wire logic [15:0] addr_lo,
    input wire logic [7:0] addr_hi,
    input wire logic ale,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in,
    output logic mem_wait_in,
    // Bench controls
    input wire logic [3:0] wait_cycles,
    output logic [15:0] wr_seen
);
    // ************************************************************
    // Address latch and strobe counter
    // ************************************************************
    logic [23:0] addr_q;
    logic [15:0] last_q;
    logic [3:0] cnt_q;

    // The address is taken while the latch enable is high.
    always @(posedge core_clk) begin
        if (ale) addr_q <= {addr_hi, addr_lo};
        if (read_strobe_n && write_strobe_n) cnt_q <= 4'h0;
        else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
        if (!read_strobe_n) last_q <= data_in;
        if (!write_strobe_n) wr_seen <= data_out;
    end

    // Slow memory holds its wait line high for the first cycles of a strobe.
    assign mem_wait_in = (!read_strobe_n || !write_strobe_n) && (cnt_q < wait_cycles);
    // Released data lines show the inverse so a stale value never matches.
    assign data_in = !read_strobe_n ? (addr_q[15:0] ^ 16'hA5C3) : ~last_q;
endmodule // ebc_mem_model

// ### verif/tb_top.sv
/*
 * Self-checking bench for the external bus controller.
 * Assumes the memory model on the bus pins and a 50 MHz core clock.
 */
`timescale 1ns/10ps

module tb_top;
    import ebc_pkg::*;
    logic core_clk = 0, rst_n = 0, cfg_load = 0, cfg_ready_en = 0, write_strobe_cfg = 0;
    logic [2:0] cfg_mode = MODE_DMX16;
    logic [1:0] cfg_space = SP_16M;
    logic [59:0] rng_base = {5{12'hFFF}}, rng_mask = 60'h0;
    logic [34:0] rng_timing = 35'h0;
    logic req_valid = 0, req_write = 0, req_byte = 0, req_ready, rsp_valid, rsp_internal;
    logic rsp_error, ale, read_strobe_n, write_strobe_n, strobe_oe, mem_wait_in;
    logic [23:0] req_addr = 24'h0;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, ad_in, ad_out, ad_oe, ao_out, ao_oe, wr_seen;
    logic [7:0] ah_out, ah_oe, p6_in = 8'hFF, p6_out, p6_oe, p2_in = 8'h00, p2_out, p2_oe;
    logic [7:0] p2_dir = 8'h00, p2_od = 8'h00, p2_gpio = 8'h00, fast_irq_in;
    logic [3:0] wait_cycles = 4'h0;
    logic hold_en = 0, saw_rd, saw_wr, saw_cs2, g_int, g_err;
    logic [15:0] g_data;
    int failures = 0, checks = 0, lat;
    logic [23:0] a;
    logic [15:0] d;

    always #10 core_clk = ~core_clk;

    ebc_top u_ebc_top (.core_clk(core_clk), .rst_n(rst_n), .cfg_load(cfg_load),
        .cfg_mode(cfg_mode), .cfg_space(cfg_space), .cfg_ready_en(cfg_ready_en),
        .write_strobe_cfg(write_strobe_cfg), .cfg_cs_en(1'b1), .cfg_hold_en(hold_en),
        .rng_base(rng_base), .rng_mask(rng_mask), .rng_timing(rng_timing),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_write(req_write), .req_byte(req_byte), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_internal(rsp_internal), .rsp_error(rsp_error),
        .rsp_rdata(rsp_rdata), .addr_data_port_in(ad_in), .addr_data_port_out(ad_out),
        .addr_data_port_oe(ad_oe), .addr_only_port_out(ao_out), .addr_only_port_oe(ao_oe),
        .addr_high_out(ah_out), .addr_high_oe(ah_oe), .ale(ale),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .strobe_oe(strobe_oe), .mem_wait_in(mem_wait_in), .p6_pin_in(p6_in),
        .p6_pin_out(p6_out), .p6_pin_oe(p6_oe), .p6_dir(8'hFF), .p6_od(8'h00),
        .p6_gpio_out(8'hFF), .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe(p2_oe),
        .p2_dir(p2_dir), .p2_od(p2_od), .p2_gpio_out(p2_gpio), .fast_irq_in(fast_irq_in));

    ebc_mem_model u_ebc_mem_model (.core_clk(core_clk), .addr_lo(ao_out), .addr_hi(ah_out),
        .ale(ale), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .data_out(ad_out), .data_in(ad_in), .mem_wait_in(mem_wait_in),
        .wait_cycles(wait_cycles), .wr_seen(wr_seen));

    // ************************************************************
    // Bus observers and helper tasks
    // ************************************************************
    // Strobes and the range-two select are noted at falling edges, where they are settled.
    always @(negedge core_clk) begin
        if (read_strobe_n === 1'b0) saw_rd = 1;
        if (write_strobe_n === 1'b0) saw_wr = 1;
        if (p6_out[2] === 1'b0 && p6_oe[2] === 1'b1) saw_cs2 = 1;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic cfg(input logic [2:0] m, input logic [1:0] s, input logic r, input logic w);
        @(negedge core_clk);
        cfg_mode = m;
        cfg_space = s;
        cfg_ready_en = r;
        write_strobe_cfg = w;
        cfg_load = 1;
        @(negedge core_clk);
        cfg_load = 0;
    endtask

    // One request held until the edge that takes it, then dropped so it is never taken twice.
    // Ready and the answer are sampled at falling edges, away from the launching edge.
    task automatic access(input logic [23:0] ad, input logic wr, input logic by,
                          input logic [15:0] wd);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1;
        req_addr = ad;
        req_write = wr;
        req_byte = by;
        req_wdata = wd;
        saw_rd = 0;
        saw_wr = 0;
        saw_cs2 = 0;
        #1;
        while (req_ready !== 1'b1 && n < 50) begin
            n++;
            @(negedge core_clk);
        end
        @(posedge core_clk);
        lat = 0;
        do begin
            @(negedge core_clk);
            if (lat == 0) req_valid = 0;
            lat++;
        end while (rsp_valid !== 1'b1 && lat < 60);
        g_int = rsp_internal;
        g_err = rsp_error;
        g_data = rsp_rdata;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rng_base[24 +: 12] = 12'h400;
        rng_mask[24 +: 12] = 12'hF00;
        rng_timing[14 +: 7] = 7'h02;
        void'($urandom(39563));
        repeat (2) @(negedge core_clk);
        rst_n = 1;
        chk("idle strobes", 3'b110, {read_strobe_n, write_strobe_n, ale});
        chk("addr port oe", 16'hFFFF, ao_oe);
        for (int s = 0; s < 4; s++) begin
            cfg(MODE_DMX16, 2'(s), 0, 0);
            chk("upper lines", (s == 3) ? 8 : 2 * s, $countones(ah_oe));
        end
        for (int i = 0; i < 8; i++) begin
            a = {8'h01 + 8'($urandom_range(2)), 16'($urandom) & 16'hFFFE};
            d = 16'($urandom);
            access(a, i[0], 0, d);
            if (i[0]) chk("write data", d, wr_seen);
            else chk("read data", a[15:0] ^ 16'hA5C3, g_data);
            chk("strobe", 2'b01, i[0] ? {saw_rd, saw_wr} : {saw_wr, saw_rd});
            chk("default latency", 3, lat);
            chk("cs2 idle", 0, saw_cs2);
        end
        access(24'h4012A0, 0, 0, 0);
        chk("cs2 active", 1, saw_cs2);
        chk("range latency", 5, lat);
        wait_cycles = 4'h3;
        access(24'h020000, 0, 0, 0);
        chk("ready off latency", 3, lat);
        cfg(MODE_DMX16, SP_16M, 1, 1);
        access(24'h020000, 0, 0, 0);
        chk("ready waits", 1, lat >= 6);
        wait_cycles = 4'h0;
        access(24'h020001, 1, 1, 16'h3C00);
        chk("high byte write", 0, saw_wr);
        access(24'h020000, 1, 1, 16'h003C);
        chk("low byte write", 1, saw_wr);
        foreach (a[i]) if (i < 4) begin
            access((i == 0) ? RAM_LO : (i == 1) ? SREG_LO + 24'h10 : (i == 2) ? XREG_LO
                   : 24'h00F200, 0, 0, 0);
            chk("internal", {i != 3, i == 3}, {g_int, saw_rd});
        end
        cfg(MODE_SINGLE, SP_16M, 0, 0);
        access(24'h030000, 0, 0, 0);
        chk("single chip", 2'b10, {g_err, saw_rd});
        cfg(MODE_DMX16, SP_16M, 0, 0);
        hold_en = 1;
        p6_in[5] = 0;
        req_valid = 1;
        repeat (3) @(negedge core_clk);
        chk("grant", 2'b00, {p6_out[6], p6_out[7]});
        chk("bus float", 1'b0, (|ao_oe) | (|ad_oe) | strobe_oe | req_ready);
        p6_in[5] = 1;
        access(24'h010000, 0, 0, 0);
        chk("after hold", 16'h0000 ^ 16'hA5C3, g_data);
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk);
            p2_in = 8'($urandom);
            p2_gpio = 8'($urandom);
            p2_od = 8'($urandom);
            p2_dir = (i == 0) ? 8'h00 : 8'hFF;
            #1;
            chk("fast irq", p2_in, fast_irq_in);
            chk("p2 drive", p2_dir & ~(p2_od & p2_gpio), p2_oe);
        end
        end_of_test();
    end

    // A hang counts as a mismatch and ends the run the same way.
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_of_test();
    end
endmodule // tb_top
